// ---- src/bps_pkg.sv ----
/*
 * constants and types shared by the board power sequencer.
 * assumes a 125 MHz system clock and a free-running 32 kHz slow clock tick input.
 */
package bps_pkg;
  // slow tick rate used for button timing
  localparam int unsigned SLOW_HZ = 32768;
  // long-hold threshold in seconds
  localparam int unsigned HOLD_S = 8;
  localparam int unsigned HOLD_TICKS = HOLD_S * SLOW_HZ;
  // debounce time in milliseconds, counted in slow ticks
  localparam int unsigned DEB_MS = 20;
  localparam int unsigned DEB_TICKS = (DEB_MS * SLOW_HZ + 999) / 1000;
  localparam int HOLD_W = 20;
  localparam int DEB_W = 10;
  // number of sequenced rails after the always-on one
  localparam int NRAIL = 6;
  // slow ticks between rail strobes
  localparam int unsigned STROBE_TICKS = 64;
  localparam int STB_W = 7;
  // reset values and rail masks
  localparam logic [NRAIL-1:0] SLEEP_KEEP_RST = 6'h01;
  localparam logic [NRAIL-1:0] RAILS_OFF = 6'h00;
  localparam logic [NRAIL-1:0] RAILS_ALL = 6'h3F;

  // Gray-coded sequencer states along off -> up -> on -> sleep
  typedef enum logic [2:0] {
    BPS_OFF = 3'b000,
    BPS_RAMP_UP = 3'b001,
    BPS_ON = 3'b011,
    BPS_SLEEP = 3'b010,
    BPS_RAMP_DOWN = 3'b110
  } bps_state_t;
endpackage

// ---- src/bps_button.sv ----
/*
 * power button conditioner: synchroniser, debounce and hold timer.
 * assumes the raw button is active low and slow_tick is a one-cycle pulse at SLOW_HZ.
 */
`timescale 1ns/1ps
module bps_button
  import bps_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic slow_tick,
  input wire logic button_n,
  output logic pressed,
  output logic press_pulse,
  output logic long_hold_pulse
);
  logic sync1;
  logic sync2;
  logic [DEB_W-1:0] deb_cnt;
  logic [HOLD_W-1:0] hold_cnt;
  logic long_done;
  wire raw_press = ~sync2;
  wire deb_full = (deb_cnt == DEB_W'(DEB_TICKS));
  wire hold_full = (hold_cnt == HOLD_W'(HOLD_TICKS));

  // two-flop synchroniser, first stage read only by second
  always_ff @(posedge clk) begin
    sync1 <= button_n;
    sync2 <= sync1;
  end

  // debounce: accept new level after stable interval
  always_ff @(posedge clk) begin
    if (srst) begin
      deb_cnt <= '0;
      pressed <= 1'b0;
    end else if (raw_press == pressed) begin
      deb_cnt <= '0;
    end else if (deb_full) begin
      deb_cnt <= '0;
      pressed <= raw_press;
    end else if (slow_tick) begin
      deb_cnt <= deb_cnt + DEB_W'(1);
    end
  end

  // hold timer on the slow tick, one long pulse per hold
  always_ff @(posedge clk) begin
    if (srst || !pressed) begin
      hold_cnt <= '0;
      long_done <= 1'b0;
    end else if (hold_full) begin
      long_done <= 1'b1;
    end else if (slow_tick) begin
      hold_cnt <= hold_cnt + HOLD_W'(1);
    end
  end

  assign press_pulse = raw_press && !pressed && deb_full;
  assign long_hold_pulse = pressed && hold_full && !long_done;
endmodule

// ---- src/bps_sequencer.sv ----
/*
 * board power sequencer core: source select, button handling, rail sequencing,
 * reset releases, wake and interrupt.
 * assumes synchronous inputs, a slow tick pulse, and that configuration ports are
 * loaded by an i2c register front end outside this module.
 */
`timescale 1ns/1ps
// How it works
// [R1] with both adapter and usb present the adapter path is chosen by hardware.
// [R2] the source in use is reported on a status port read over the i2c port.
// [R3] running from usb, arrival of the adapter switches over at once.
// [R4] a short press while powered raises the interrupt output.
// [R5] the processor drops the enable request when it chooses after an interrupt.
// [R6] in power-off with input still present a press starts the power-up again.
// [R7] a hold of more than eight seconds forces power-down and darkens the indicator.
// [R8] if still held after the forced power-down the block powers up again.
// [R9] the processor raises the enable request once its clock domain is alive.
// [R10] the processor lowers the enable request to ask for power-down.
// [R11] always-on rail good rises once the clock rail is stable, releasing its reset.
// [R12] all-rails good rises only when every rail is up, releasing the main reset.
// [R13] a button press while the processor sleeps raises the wake output.
// [R14] by default only the first standby regulator stays on in sleep, others configurable.
// [R15] software may force the step-down converters into fixed-frequency pwm.
// [R16] power configuration written over the i2c port is accepted and applied.
// [R17] the button is synchronised, debounced and timed on a slow free-running clock.
module bps_sequencer
  import bps_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic slow_tick,
  input wire logic adapter_present,
  input wire logic usb_present,
  input wire logic usb_path_disable,
  input wire logic button_n,
  input wire logic power_enable_request,
  input wire logic sleep_request,
  input wire logic rtc_rail_stable,
  input wire logic [bps_pkg::NRAIL-1:0] rail_up,
  input wire logic cfg_write,
  input wire logic [bps_pkg::NRAIL-1:0] cfg_sleep_keep,
  input wire logic cfg_force_pwm,
  input wire logic irq_clear,
  output logic source_is_adapter,
  output logic source_is_usb,
  output logic [bps_pkg::NRAIL-1:0] rail_enable,
  output logic standby_regulator_one,
  output logic buck_force_pwm,
  output logic always_on_rail_good,
  output logic all_rails_good,
  output logic power_indicator,
  output logic power_event_irq_n,
  output logic power_event_irq_oe_n,
  output logic cpu_wake_input,
  output logic [2:0] seq_state
);
  import bps_pkg::*;

  bps_state_t state;
  bps_state_t next_state;
  logic [NRAIL-1:0] sleep_keep;
  logic force_pwm;
  logic irq_flag;
  logic [STB_W-1:0] stb_cnt;
  logic [NRAIL-1:0] next_rails;
  logic hold_restart;
  logic forced_off;
  logic pressed;
  logic press_pulse;
  logic long_hold_pulse;

  // [R17] conditioned button
  bps_button u_button (
    .clk(clk),
    .srst(srst),
    .slow_tick(slow_tick),
    .button_n(button_n),
    .pressed(pressed),
    .press_pulse(press_pulse),
    .long_hold_pulse(long_hold_pulse)
  );

  wire input_ok = adapter_present || (usb_present && !usb_path_disable);
  wire stb_due = slow_tick && (stb_cnt == STB_W'(STROBE_TICKS - 1));
  wire all_up = (rail_up == RAILS_ALL);
  wire all_down = (rail_up == RAILS_OFF);

  // state sequencing
  always_comb begin
    next_state = state;
    if (!input_ok) begin
      next_state = BPS_OFF;
    end else begin
      case (state)
        BPS_OFF: begin
          // [R6] press restarts; [R8] held after forced off
          if (press_pulse || (hold_restart && pressed) ||
              (power_enable_request && !forced_off)) begin
            next_state = BPS_RAMP_UP;
          end
        end
        BPS_RAMP_UP: begin
          // [R10] enable request low sends a finished ramp down instead of on
          if (!power_enable_request && !hold_restart && !press_pulse && all_up) begin
            next_state = BPS_RAMP_DOWN;
          end else if (all_up) begin
            next_state = BPS_ON;
          end
        end
        BPS_ON: begin
          // [R10] processor requests power-down
          if (!power_enable_request) begin
            next_state = BPS_RAMP_DOWN;
          end else if (sleep_request) begin
            next_state = BPS_SLEEP;
          end
        end
        BPS_SLEEP: begin
          if (!power_enable_request) begin
            next_state = BPS_RAMP_DOWN;
          end else if (!sleep_request) begin
            next_state = BPS_ON;
          end
        end
        BPS_RAMP_DOWN: begin
          if (all_down) begin
            next_state = BPS_OFF;
          end
        end
        default: next_state = BPS_OFF;
      endcase
      // [R7] long hold overrides the state case outside off, but not input loss
      if (long_hold_pulse && state != BPS_OFF) begin
        next_state = BPS_RAMP_DOWN;
      end
    end
  end

  // rail enables: step one rail per strobe, reverse order going down
  always_comb begin
    next_rails = rail_enable;
    case (state)
      BPS_RAMP_UP: if (stb_due) next_rails = {rail_enable[NRAIL-2:0], 1'b1};
      BPS_RAMP_DOWN: if (stb_due) next_rails = {1'b0, rail_enable[NRAIL-1:1]};
      // [R14] sleep keeps configured rails only
      BPS_SLEEP: next_rails = RAILS_ALL & sleep_keep;
      BPS_ON: next_rails = RAILS_ALL;
      default: next_rails = RAILS_OFF;
    endcase
  end

  // state, strobe and rail registers
  always_ff @(posedge clk) begin
    if (srst) begin
      state <= BPS_OFF;
      rail_enable <= RAILS_OFF;
      stb_cnt <= '0;
    end else begin
      state <= next_state;
      rail_enable <= next_rails;
      // wrap at the strobe spacing, not at the counter width
      if (stb_due) begin
        stb_cnt <= '0;
      end else if (slow_tick) begin
        stb_cnt <= stb_cnt + STB_W'(1);
      end
    end
  end

  // [R7] forced power-down ignores a standing enable
  // until the enable drops or the button restarts the ramp
  always_ff @(posedge clk) begin
    if (srst) begin
      forced_off <= 1'b0;
    end else if (long_hold_pulse && state != BPS_OFF) begin
      forced_off <= 1'b1;
    end else if (!power_enable_request || state == BPS_RAMP_UP) begin
      forced_off <= 1'b0;
    end
  end

  // [R8] remember a forced power-down until button release
  always_ff @(posedge clk) begin
    if (srst || !pressed) begin
      hold_restart <= 1'b0;
    end else if (long_hold_pulse) begin
      hold_restart <= 1'b1;
    end
  end

  // [R16] configuration written over the control port
  always_ff @(posedge clk) begin
    if (srst) begin
      sleep_keep <= SLEEP_KEEP_RST;
      force_pwm <= 1'b0;
    end else if (cfg_write) begin
      sleep_keep <= cfg_sleep_keep;
      force_pwm <= cfg_force_pwm;
    end
  end

  // [R4] sticky interrupt, set wins over clear
  always_ff @(posedge clk) begin
    if (srst) begin
      irq_flag <= 1'b0;
    end else if (press_pulse && (state == BPS_ON || state == BPS_SLEEP)) begin
      irq_flag <= 1'b1;
    end else if (irq_clear) begin
      irq_flag <= 1'b0;
    end
  end

  // registered status outputs
  always_ff @(posedge clk) begin
    if (srst) begin
      source_is_adapter <= 1'b0;
      source_is_usb <= 1'b0;
      always_on_rail_good <= 1'b0;
      all_rails_good <= 1'b0;
      cpu_wake_input <= 1'b0;
      buck_force_pwm <= 1'b0;
    end else begin
      // [R1] [R3] adapter preferred, [R2] reported
      source_is_adapter <= adapter_present;
      source_is_usb <= !adapter_present && usb_present && !usb_path_disable;
      // [R11] always-on rail good follows the stable clock rail
      always_on_rail_good <= input_ok && rtc_rail_stable;
      // [R12] good only with every rail up and sequenced
      all_rails_good <= all_up && (state == BPS_ON || state == BPS_SLEEP);
      // [R13] wake pulse on press during sleep
      cpu_wake_input <= press_pulse && (state == BPS_SLEEP);
      // [R15] forced pwm from configuration
      buck_force_pwm <= force_pwm;
    end
  end

  // always-on regulator stays up while input is present
  assign standby_regulator_one = input_ok;
  // [R7] indicator dark as soon as the ramp-down starts
  assign power_indicator = (state == BPS_ON) || (state == BPS_SLEEP);
  // open-drain interrupt: drive low while pending
  assign power_event_irq_n = 1'b0;
  assign power_event_irq_oe_n = !irq_flag;
  assign seq_state = state;
endmodule

// ---- test/bps_chk_sva.sv ----
/* port assertions for the sequencer.
   assumes it is bound onto bps_sequencer. */
`timescale 1ns/1ps
module bps_chk
  import bps_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic adapter_present,
  input wire logic usb_present,
  input wire logic rtc_rail_stable,
  input wire logic [bps_pkg::NRAIL-1:0] rail_up,
  input wire logic cfg_write,
  input wire logic cfg_force_pwm,
  input wire logic irq_clear,
  input wire logic source_is_adapter,
  input wire logic source_is_usb,
  input wire logic buck_force_pwm,
  input wire logic always_on_rail_good,
  input wire logic all_rails_good,
  input wire logic power_indicator,
  input wire logic power_event_irq_n,
  input wire logic power_event_irq_oe_n,
  input wire logic cpu_wake_input
);
  import bps_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // port relations
  AST_SRC_BOTH: assert property (adapter_present && usb_present && !srst |=> source_is_adapter)
    else $error("adapter not chosen");
  AST_SRC_USB: assert property (source_is_usb |-> !source_is_adapter && $past(usb_present))
    else $error("usb status wrong");
  AST_IRQ_LOW: assert property (power_event_irq_n == 1'h0)
    else $error("irq line not low");
  AST_IRQ_HOLD: assert property (!power_event_irq_oe_n && !irq_clear |=> !power_event_irq_oe_n)
    else $error("irq dropped");
  AST_PGOOD: assert property (all_rails_good |-> $past(rail_up) == RAILS_ALL && $past(power_indicator))
    else $error("pgood early");
  AST_AORG: assert property (always_on_rail_good |-> $past(rtc_rail_stable))
    else $error("rtc good early");
  AST_WAKE: assert property (cpu_wake_input |=> !cpu_wake_input)
    else $error("wake too long");
  AST_PWM: assert property (cfg_write |-> ##2 buck_force_pwm == $past(cfg_force_pwm, 2))
    else $error("pwm not loaded");
  // main scenarios
  cover property (all_rails_good);
  cover property (!power_event_irq_oe_n);
  cover property (cpu_wake_input);
endmodule
bind bps_sequencer bps_chk bps_chk_i (.*);

// ---- test/bps_host.sv ----
/* processor and rail feedback model.
   assumes it faces bps_sequencer directly. */
`timescale 1ns/1ps
module bps_host
  import bps_pkg::*;
#(parameter int DLY = 3)
(
  input wire logic clk,
  input wire logic srst,
  input wire logic go_down,
  input wire logic always_on_rail_good,
  input wire logic [bps_pkg::NRAIL-1:0] rail_enable,
  output logic power_enable_request,
  output logic [bps_pkg::NRAIL-1:0] rail_up
);
  import bps_pkg::*;
  logic [NRAIL-1:0] pipe [DLY];
  always_ff @(posedge clk) begin
    power_enable_request <= !srst && always_on_rail_good && !go_down;
  end
  // rails come up a few cycles after enable
  always_ff @(posedge clk) begin
    pipe[0] <= srst ? RAILS_OFF : rail_enable;
    for (int i = 1; i < DLY; i++) begin
      pipe[i] <= pipe[i-1];
    end
  end
  assign rail_up = pipe[DLY-1];
endmodule

// ---- test/bps_tb_top.sv ----
/* self-checking bench for the sequencer.
   assumes slow_tick held high, so each clock is a slow tick. */
`timescale 1ns/1ps
module bps_tb_top;
  import bps_pkg::*;
  logic clk, srst, slow_tick, adapter_present, usb_present, usb_path_disable;
  logic button_n, sleep_request, rtc_rail_stable, cfg_write, cfg_force_pwm;
  logic irq_clear, go_down, power_enable_request, always_on_rail_good;
  logic source_is_adapter, source_is_usb, standby_regulator_one, buck_force_pwm;
  logic all_rails_good, power_indicator, power_event_irq_n, power_event_irq_oe_n;
  logic cpu_wake_input;
  logic [NRAIL-1:0] cfg_sleep_keep, rail_up, rail_enable;
  logic [2:0] seq_state;
  int error_cnt = 0;
  int num_checks = 0;
  int wake_cnt = 0;
  int wake_base = 0;
  // adapter, usb, expected adapter, expected usb
  logic [3:0] rows [3] = '{4'h5, 4'hE, 4'hA};
  bps_sequencer bps_sequencer_i (.*);
  bps_host #(.DLY(3)) bps_host_i (.*);
  // clock and watchdog
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  initial begin
    #160000;
    error_cnt++;
    results();
  end
  always @(posedge clk) begin
    if (cpu_wake_input === 1'h1) wake_cnt <= wake_cnt + 1;
  end
  task automatic cyc(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(string nm, logic [5:0] ex, logic [5:0] got);
    num_checks++;
    if (got !== ex) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, ex, got);
    end
  endtask
  task automatic wait_st(logic [2:0] s);
    for (int i = 0; i < 3000 && seq_state !== s; i++) cyc(1);
  endtask
  // let an earlier release settle, then hold past the debounce
  task automatic press();
    cyc(DEB_TICKS + 8);
    button_n = 0;
    cyc(DEB_TICKS + 8);
    button_n = 1;
  endtask
  task automatic results();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    {srst, slow_tick, button_n, rtc_rail_stable} = 4'hF;
    {adapter_present, usb_present, usb_path_disable, sleep_request} = 4'h0;
    {cfg_write, cfg_force_pwm, irq_clear, go_down} = 4'h0;
    cfg_sleep_keep = 6'h03;
    cyc(3);
    srst = 0;
    foreach (rows[i]) begin
      {adapter_present, usb_present} = rows[i][3:2];
      cyc(2);
      chk("src", rows[i][1:0], {source_is_adapter, source_is_usb});
    end
    wait_st(3'h3);
    cyc(2);
    chk("on", 6'h3, seq_state);
    chk("good", 6'h7, {always_on_rail_good, all_rails_good, power_indicator});
    chk("standby_regulator_one", 6'h1, standby_regulator_one);
    press();
    chk("irq", 6'h0, power_event_irq_oe_n);
    irq_clear = 1;
    cyc(1);
    irq_clear = 0;
    cyc(1);
    chk("irq_clr", 6'h1, power_event_irq_oe_n);
    // a bounce shorter than the debounce is ignored
    button_n = 0;
    cyc(100);
    button_n = 1;
    cyc(DEB_TICKS + 8);
    chk("bounce", 6'h1, power_event_irq_oe_n);
    sleep_request = 1;
    wait_st(3'h2);
    cyc(500);
    chk("keep", SLEEP_KEEP_RST, rail_enable);
    wake_base = wake_cnt;
    press();
    cyc(2);
    chk("wake", 6'h1, 6'(wake_cnt - wake_base));
    cfg_force_pwm = 1;
    cfg_write = 1;
    cyc(1);
    cfg_write = 0;
    cyc(1);
    chk("pwm", 6'h1, buck_force_pwm);
    chk("keep_cfg", cfg_sleep_keep, rail_enable);
    sleep_request = 0;
    go_down = 1;
    wait_st(3'h0);
    cyc(2);
    chk("off", 6'h0, {all_rails_good, power_indicator, rail_enable[0]});
    press();
    chk("restart", 6'h1, seq_state);
    srst = 1;
    cyc(1);
    chk("rst", 6'h0, rail_enable);
    chk("rst_st", 6'h0, seq_state);
    chk("rst_irq", 6'h1, power_event_irq_oe_n);
    srst = 0;
    results();
  end
endmodule
